// [loop_bw_regs.sv]
// loop bandwidth configuration registers for two digital loops
// assumes the serial configuration port hands over byte accesses on sys_clk_i
// and that loop status and neighbour-register bits arrive on the same clock
//
// Function
// - Second loop code 00/01/10 selects 18/35/70 Hz; code 11 is unused.
// - Locked code 11/00/01 gives 18/35/70 Hz; mode bit: always or locked.
// - Acquire code 11/00/01 gives 18/35/70 Hz while acquiring; 10 unused.
// - Mode bit ignores acquire bandwidth or applies it while unlocked.
// - Damping bits 6:4 set detector gain, used only when gain select is on.
`timescale 1ns/1ns
`include "loop_bw_cfg.svh"
module loop_bw_regs (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] cfg_addr_i,
	input  wire logic [7:0] cfg_wdata_i,
	input  wire logic       cfg_wr_i,
	input  wire logic       cfg_rd_i,
	output logic      [7:0] cfg_rdata_o,
	output logic            cfg_rvalid_o,
	input  wire logic       first_locked_i,
	input  wire logic       auto_bw_sel_i,
	input  wire logic       gain_sel_en_i,
	output logic      [2:0] second_bw_o,
	output logic      [2:0] first_bw_o,
	output logic      [2:0] detector_gain_o,
	output logic            detector_gain_en_o,
	output logic      [2:0] second_damping_o
);

	////////////////////////////////////////////////////////////////////////
	// register storage

	logic [7:0] second_bw_q;
	logic [7:0] first_locked_q;
	logic [7:0] first_acq_q;
	logic [7:0] damping_q;

	// masked writes keep unused positions at zero
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			second_bw_q    <= `RST_SECOND_LOOP_BANDWIDTH
				& `MASK_SECOND_LOOP_BANDWIDTH;
			first_locked_q <= `RST_FIRST_LOOP_LOCKED_BANDWIDTH
				& `MASK_FIRST_LOOP_LOCKED_BANDWIDTH;
			first_acq_q    <= `RST_FIRST_LOOP_ACQUIRE_BANDWIDTH
				& `MASK_FIRST_LOOP_ACQUIRE_BANDWIDTH;
			damping_q      <= `RST_SECOND_LOOP_DAMPING_GAIN
				& `MASK_SECOND_LOOP_DAMPING_GAIN;
		end else if (cfg_wr_i) begin
			case (cfg_addr_i)
				`ADDR_SECOND_LOOP_BANDWIDTH: begin
					second_bw_q <= cfg_wdata_i & `MASK_SECOND_LOOP_BANDWIDTH;
				end
				`ADDR_FIRST_LOOP_LOCKED_BANDWIDTH: begin
					first_locked_q <= cfg_wdata_i
						& `MASK_FIRST_LOOP_LOCKED_BANDWIDTH;
				end
				`ADDR_FIRST_LOOP_ACQUIRE_BANDWIDTH: begin
					first_acq_q <= cfg_wdata_i
						& `MASK_FIRST_LOOP_ACQUIRE_BANDWIDTH;
				end
				`ADDR_SECOND_LOOP_DAMPING_GAIN: begin
					damping_q <= cfg_wdata_i & `MASK_SECOND_LOOP_DAMPING_GAIN;
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port: one cycle latency, unmapped addresses return zero

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_rdata_o  <= 8'h00;
			cfg_rvalid_o <= 1'b0;
		end else begin
			cfg_rvalid_o <= cfg_rd_i;
			if (cfg_rd_i) begin
				case (cfg_addr_i)
					`ADDR_SECOND_LOOP_BANDWIDTH:        cfg_rdata_o <= second_bw_q;
					`ADDR_FIRST_LOOP_LOCKED_BANDWIDTH:  cfg_rdata_o <= first_locked_q;
					`ADDR_FIRST_LOOP_ACQUIRE_BANDWIDTH: cfg_rdata_o <= first_acq_q;
					`ADDR_SECOND_LOOP_DAMPING_GAIN:     cfg_rdata_o <= damping_q;
					default:                            cfg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// code decoders

	loop_bw_pkg::bw_onehot_t second_sel;
	loop_bw_pkg::bw_onehot_t locked_sel;
	loop_bw_pkg::bw_onehot_t acq_sel;
	logic                    second_ok;
	logic                    locked_ok;
	logic                    acq_ok;

	bw_code_decode #(
		.CODE_18 (`SECOND_CODE_18),
		.CODE_35 (`SECOND_CODE_35),
		.CODE_70 (`SECOND_CODE_70)
	) u_second_dec (
		.code_i  (second_bw_q[1:0]),
		.sel_o   (second_sel),
		.valid_o (second_ok)
	);

	bw_code_decode #(
		.CODE_18 (`FIRST_CODE_18),
		.CODE_35 (`FIRST_CODE_35),
		.CODE_70 (`FIRST_CODE_70)
	) u_locked_dec (
		.code_i  (first_locked_q[1:0]),
		.sel_o   (locked_sel),
		.valid_o (locked_ok)
	);

	// only the low two bits of the acquire field carry a code
	bw_code_decode #(
		.CODE_18 (`FIRST_CODE_18),
		.CODE_35 (`FIRST_CODE_35),
		.CODE_70 (`FIRST_CODE_70)
	) u_acq_dec (
		.code_i  (first_acq_q[1:0]),
		.sel_o   (acq_sel),
		.valid_o (acq_ok)
	);

	////////////////////////////////////////////////////////////////////////
	// second loop bandwidth; a reserved code keeps the last legal choice

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			second_bw_o <= loop_bw_pkg::BW_18HZ;
		end else if (second_ok) begin
			second_bw_o <= second_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// first loop bandwidth: acquire value only in auto mode while unlocked

	logic use_acq;
	assign use_acq = auto_bw_sel_i && !first_locked_i;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			first_bw_o <= loop_bw_pkg::BW_35HZ;
		end else if (use_acq) begin
			if (acq_ok) begin
				first_bw_o <= acq_sel;
			end
		end else if (locked_ok) begin
			first_bw_o <= locked_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// second detector gain and damping fields

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			detector_gain_o    <= 3'h0;
			detector_gain_en_o <= 1'b0;
			second_damping_o   <= 3'h0;
		end else begin
			detector_gain_o <= damping_q[`GAIN_FIELD_MSB:`GAIN_FIELD_LSB];
			detector_gain_en_o <= gain_sel_en_i;
			second_damping_o <= damping_q[`DAMPING_FIELD_MSB:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_write(logic [7:0] a);
		cfg_wr_i && cfg_addr_i == a;
	endsequence

	AST_SECOND_BW_MAP: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		second_ok |=> second_bw_o == $past(second_sel))
		else $error("second loop bandwidth not taken from its code");

	AST_SECOND_70: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		second_bw_q[1:0] == 2'h2 |=> second_bw_o == loop_bw_pkg::BW_70HZ)
		else $error("second loop code 10 did not give 70 Hz");

	AST_LOCKED_18: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!use_acq && first_locked_q[1:0] == 2'h3)
		|=> first_bw_o == loop_bw_pkg::BW_18HZ)
		else $error("locked code 11 did not give 18 Hz");

	AST_ACQ_70: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(use_acq && first_acq_q[1:0] == 2'h1)
		|=> first_bw_o == loop_bw_pkg::BW_70HZ)
		else $error("acquire code 01 did not give 70 Hz while acquiring");

	AST_ACQ_IGNORED: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(!auto_bw_sel_i && locked_ok) |=> first_bw_o == $past(locked_sel))
		else $error("acquire bandwidth used while mode bit ignores it");

	AST_GAIN_WRITE: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_write(`ADDR_SECOND_LOOP_DAMPING_GAIN) ##2 1'b1
		|-> detector_gain_o == $past(cfg_wdata_i[6:4], 2))
		else $error("detector gain not updated two cycles after write");

	AST_UNUSED_ZERO: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(cfg_rd_i && cfg_addr_i == `ADDR_SECOND_LOOP_BANDWIDTH)
		|=> cfg_rvalid_o && cfg_rdata_o[7:2] == 6'h00)
		else $error("unused bits of second loop bandwidth read nonzero");

	AST_RESERVED_HOLD: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(second_bw_q[1:0] == 2'h3) |=> $stable(second_bw_o))
		else $error("reserved second loop code changed the loop");

endmodule // loop_bw_regs

// [loop_bw_cfg.svh]
// register offsets, field positions, reset values and code maps for the
// loop bandwidth configuration bank; assumes an 8-bit register address space
`ifndef LOOP_BW_CFG_SVH
`define LOOP_BW_CFG_SVH

`define ADDR_SECOND_LOOP_BANDWIDTH       8'h66
`define ADDR_FIRST_LOOP_LOCKED_BANDWIDTH 8'h67
`define ADDR_FIRST_LOOP_ACQUIRE_BANDWIDTH 8'h69
`define ADDR_SECOND_LOOP_DAMPING_GAIN    8'h6A

`define RST_SECOND_LOOP_BANDWIDTH        8'h00
`define RST_FIRST_LOOP_LOCKED_BANDWIDTH  8'h10
`define RST_FIRST_LOOP_ACQUIRE_BANDWIDTH 8'h11
`define RST_SECOND_LOOP_DAMPING_GAIN     8'h13

// bits that hold storage; all others ignore writes and read as zero
`define MASK_SECOND_LOOP_BANDWIDTH       8'h03
`define MASK_FIRST_LOOP_LOCKED_BANDWIDTH 8'h03
`define MASK_FIRST_LOOP_ACQUIRE_BANDWIDTH 8'h0F
`define MASK_SECOND_LOOP_DAMPING_GAIN    8'h77

`define GAIN_FIELD_LSB                   4
`define GAIN_FIELD_MSB                   6
`define DAMPING_FIELD_MSB                2

// bandwidth code maps
`define SECOND_CODE_18                   2'h0
`define SECOND_CODE_35                   2'h1
`define SECOND_CODE_70                   2'h2
`define FIRST_CODE_18                    2'h3
`define FIRST_CODE_35                    2'h0
`define FIRST_CODE_70                    2'h1

`endif

// [loop_bw_pkg.sv]
// types shared by the loop bandwidth configuration bank
// assumes nothing beyond a SystemVerilog compiler
package loop_bw_pkg;
	// one-hot bandwidth selection driven to a loop
	typedef enum logic [2:0] {
		BW_NONE = 3'h0,
		BW_18HZ = 3'h1,
		BW_35HZ = 3'h2,
		BW_70HZ = 3'h4
	} bw_onehot_t;

	typedef logic [7:0] reg_byte_t;
endpackage

// [bw_code_decode.sv]
// decodes a two-bit bandwidth code into a one-hot selection
// assumes the caller holds the last legal value when valid_o is low
`timescale 1ns/1ns
module bw_code_decode #(
	parameter logic [1:0] CODE_18 = 2'h0,
	parameter logic [1:0] CODE_35 = 2'h1,
	parameter logic [1:0] CODE_70 = 2'h2
) (
	input  wire logic [1:0] code_i,
	output loop_bw_pkg::bw_onehot_t sel_o,
	output logic            valid_o
);
	// the leftover code maps to nothing, so reserved values never steer a loop
	always_comb begin
		sel_o   = loop_bw_pkg::BW_NONE;
		valid_o = 1'b1;
		if (code_i == CODE_18) begin
			sel_o = loop_bw_pkg::BW_18HZ;
		end else if (code_i == CODE_35) begin
			sel_o = loop_bw_pkg::BW_35HZ;
		end else if (code_i == CODE_70) begin
			sel_o = loop_bw_pkg::BW_70HZ;
		end else begin
			valid_o = 1'b0;
		end
	end
endmodule // bw_code_decode

// [testbench.sv]
// self-checking bench for the loop bandwidth configuration registers
// assumes loop_bw_regs and its header; inputs change on falling edges
`timescale 1ns/1ns
`include "loop_bw_cfg.svh"
module testbench;
	logic       sys_clk_i = 1'b0;
	logic       rst_i = 1'b1;
	logic [7:0] cfg_addr_i = 8'h00;
	logic [7:0] cfg_wdata_i = 8'h00;
	logic       cfg_wr_i = 1'b0;
	logic       cfg_rd_i = 1'b0;
	logic       first_locked_i = 1'b0;
	logic       auto_bw_sel_i = 1'b0;
	logic       gain_sel_en_i = 1'b0;
	logic [7:0] cfg_rdata_o;
	logic       cfg_rvalid_o;
	logic [2:0] second_bw_o;
	logic [2:0] first_bw_o;
	logic [2:0] detector_gain_o;
	logic       detector_gain_en_o;
	logic [2:0] second_damping_o;
	logic [7:0] m66, m67, m69, m6a, r;
	logic [2:0] exp_sec, exp_first;
	int         n_fail = 0;
	int         num_checks = 0;
	int         cycles = 0;

	////////////////////////////////////////////////////////////////////////
	// clock and hang guard; a full run needs well under 3000 cycles
	always #5 sys_clk_i = ~sys_clk_i;
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			n_fail++;
			results();
		end
	end

	loop_bw_regs dut (
		.sys_clk_i          (sys_clk_i),
		.rst_i              (rst_i),
		.cfg_addr_i         (cfg_addr_i),
		.cfg_wdata_i        (cfg_wdata_i),
		.cfg_wr_i           (cfg_wr_i),
		.cfg_rd_i           (cfg_rd_i),
		.cfg_rdata_o        (cfg_rdata_o),
		.cfg_rvalid_o       (cfg_rvalid_o),
		.first_locked_i     (first_locked_i),
		.auto_bw_sel_i      (auto_bw_sel_i),
		.gain_sel_en_i      (gain_sel_en_i),
		.second_bw_o        (second_bw_o),
		.first_bw_o         (first_bw_o),
		.detector_gain_o    (detector_gain_o),
		.detector_gain_en_o (detector_gain_en_o),
		.second_damping_o   (second_damping_o)
	);

	////////////////////////////////////////////////////////////////////////
	// helpers: stimulus source, expected decode, compare and verdict
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction

	// one-hot {70,35,18}; zero marks a reserved code
	function automatic logic [2:0] dec(input logic [1:0] c, input logic f);
		return f ? {c == 2'h1, c == 2'h0, c == 2'h3}
			: {c == 2'h2, c == 2'h1, c == 2'h0};
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// every intermediate state lasts an edge, so reserved codes hold it
	task automatic upd();
		logic [1:0] s;
		s = (auto_bw_sel_i && !first_locked_i) ? m69[1:0] : m67[1:0];
		if (dec(m66[1:0], 1'b0) != 3'h0) exp_sec = dec(m66[1:0], 1'b0);
		if (dec(s, 1'b1) != 3'h0) exp_first = dec(s, 1'b1);
	endtask

	task automatic rst_model();
		m66 = `RST_SECOND_LOOP_BANDWIDTH & `MASK_SECOND_LOOP_BANDWIDTH;
		m67 = `RST_FIRST_LOOP_LOCKED_BANDWIDTH & `MASK_FIRST_LOOP_LOCKED_BANDWIDTH;
		m69 = `RST_FIRST_LOOP_ACQUIRE_BANDWIDTH & `MASK_FIRST_LOOP_ACQUIRE_BANDWIDTH;
		m6a = `RST_SECOND_LOOP_DAMPING_GAIN & `MASK_SECOND_LOOP_DAMPING_GAIN;
		upd();
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		cfg_addr_i = a;
		cfg_wdata_i = d;
		cfg_wr_i = 1'b1;
		@(negedge sys_clk_i);
		cfg_wr_i = 1'b0;
		case (a)
			`ADDR_SECOND_LOOP_BANDWIDTH: m66 = d & `MASK_SECOND_LOOP_BANDWIDTH;
			`ADDR_FIRST_LOOP_LOCKED_BANDWIDTH: m67 = d & 8'h03;
			`ADDR_FIRST_LOOP_ACQUIRE_BANDWIDTH: m69 = d & 8'h0F;
			`ADDR_SECOND_LOOP_DAMPING_GAIN: m6a = d & 8'h77;
			default: ;
		endcase
		upd();
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		@(negedge sys_clk_i);
		cfg_addr_i = a;
		cfg_rd_i = 1'b1;
		@(negedge sys_clk_i);
		cfg_rd_i = 1'b0;
		check({7'h00, cfg_rvalid_o}, 8'h01);
		check(cfg_rdata_o, want);
	endtask

	task automatic read_all();
		rd(`ADDR_SECOND_LOOP_BANDWIDTH, m66);
		rd(`ADDR_FIRST_LOOP_LOCKED_BANDWIDTH, m67);
		rd(`ADDR_FIRST_LOOP_ACQUIRE_BANDWIDTH, m69);
		rd(`ADDR_SECOND_LOOP_DAMPING_GAIN, m6a);
		rd(8'h68, 8'h00);
	endtask

	task automatic chk_out();
		@(negedge sys_clk_i);
		check({5'h00, second_bw_o}, {5'h00, exp_sec});
		check({5'h00, first_bw_o}, {5'h00, exp_first});
		check({5'h00, detector_gain_o}, {5'h00, m6a[6:4]});
		check({7'h00, detector_gain_en_o}, {7'h00, gain_sel_en_i});
		check({5'h00, second_damping_o}, {5'h00, m6a[2:0]});
	endtask

	////////////////////////////////////////////////////////////////////////
	// reset, random configurations with reserved codes, then a second reset
	initial begin
		r = 8'h42;
		repeat (20) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 1'b0;
		rst_model();
		chk_out();
		read_all();
		for (int i = 0; i < 64; i++) begin
			r = lfsr(r);
			@(negedge sys_clk_i);
			first_locked_i = r[0];
			auto_bw_sel_i = r[1];
			gain_sel_en_i = r[2];
			upd();
			wr(`ADDR_SECOND_LOOP_BANDWIDTH, r);
			wr(`ADDR_FIRST_LOOP_LOCKED_BANDWIDTH, {r[3:0], r[7:4]});
			wr(`ADDR_FIRST_LOOP_ACQUIRE_BANDWIDTH, ~r);
			wr(`ADDR_SECOND_LOOP_DAMPING_GAIN, r ^ 8'h5C);
			wr(8'h68, r);
			chk_out();
			if (i % 8 == 0) read_all();
		end
		@(negedge sys_clk_i);
		rst_i = 1'b1;
		@(negedge sys_clk_i);
		rst_i = 1'b0;
		rst_model();
		chk_out();
		read_all();
		results();
	end
endmodule // testbench
